// ### vint_pkg.sv
// Package with register map, vectors and field layout of the vectored interrupt unit.
`default_nettype none
package vint_pkg;
  localparam int NUM_SRC = 8;
  localparam logic [7:0] ADDR_PENDING = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] PENDING_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam int SRC_TIMER = 0;
  localparam int SRC_EXT_A = 1;
  localparam int SRC_EXT_B = 2;
  localparam int SRC_CNT1 = 3;
  localparam int SRC_CNT2 = 4;
  localparam int SRC_HPW = 5;
  localparam int SRC_LPW = 6;
  localparam int SRC_PORT = 7;
  localparam int CTRL_GIE_BIT = 0;
  localparam int STATE_BUSY_BIT = 1;
  localparam int ISTAT_TAKE_BIT = 0;
  localparam int ISTAT_DONE_BIT = 1;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0003;
endpackage
`default_nettype wire

// ### vint_edge_sync.sv
// Two-flop synchroniser with a falling-edge detector for one request line.
`default_nettype none
module vint_edge_sync
  import vint_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic async_i,
  input wire logic sync_mode_i,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic cur;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else if (ce_i) begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  // Internal sources are on this clock and skip the synchroniser.
  assign cur = sync_mode_i ? sync_r : async_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b1;
    end else if (ce_i) begin
      prev_r <= cur;
    end
  end

  assign fall_o = ce_i & prev_r & ~cur;
endmodule
`default_nettype wire

// ### vint_context_store.sv
// Hardware save slot for the accumulator and CPU status register.
`default_nettype none
module vint_context_store
  import vint_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic save_i,
  input wire logic [DATA_W-1:0] acc_i,
  input wire logic [DATA_W-1:0] stat_i,
  output logic [DATA_W-1:0] acc_o,
  output logic [DATA_W-1:0] stat_o
);
  initial begin
    if (DATA_W < 1) begin
      $error("DATA_W must be positive.");
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_o <= '0;
      stat_o <= '0;
    end else if (ce_i && save_i) begin
      acc_o <= acc_i;
      stat_o <= stat_i;
    end
  end
endmodule
`default_nettype wire

// ### vint_unit.sv
// Vectored interrupt unit: pending flags, mask, vectoring and context save.
`default_nettype none
module vint_unit
  import vint_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [3:0] INT_SRC_I,
  input wire logic EXT_IRQ_PIN_A_I,
  input wire logic EXT_IRQ_PIN_B_I,
  input wire logic PORT_CHANGE_I,
  input wire logic GLOBAL_ENABLE_INSTR_I,
  input wire logic GLOBAL_DISABLE_INSTR_I,
  input wire logic FREE_TIMER_OVF_I,
  input wire logic TAKE_ACK_I,
  input wire logic RETURN_I,
  input wire logic [DATA_W-1:0] ACCUMULATOR_I,
  input wire logic [DATA_W-1:0] CPU_STATUS_I,
  output logic TAKE_REQ_O,
  output logic [15:0] VECTOR_O,
  output logic RESTORE_O,
  output logic [DATA_W-1:0] ACC_RESTORE_O,
  output logic [DATA_W-1:0] STATUS_RESTORE_O,
  output logic IRQ_O
);
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_SERVICE} vstate_t;

  initial begin
    if (NUM_SRC != 8) begin
      $error("The unit serves exactly eight sources.");
    end
    if (DATA_W < 1) begin
      $error("DATA_W must be positive.");
    end
  end

  vstate_t state_r;
  logic [NUM_SRC-1:0] pending_flag_register_r;
  logic [NUM_SRC-1:0] source_mask_register_r;
  logic [NUM_SRC-1:0] req_lines;
  logic [NUM_SRC-1:0] fall;
  logic [NUM_SRC-1:0] is_pin;
  logic [NUM_SRC-1:0] clr_bits;
  logic [NUM_SRC-1:0] eligible;
  logic [2:0] sel_idx;
  logic [2:0] cur_idx_r;
  logic gie_r;
  logic sel_any;
  logic take;
  logic done;
  logic wr_en;
  logic rd_en;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  logic addr_ok;

  // Lowest index wins, which is also the lowest vector address.
  function automatic logic [2:0] low_idx(input logic [NUM_SRC-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    return VEC_BASE + 16'(VEC_STEP * 16'(idx));
  endfunction

  assign req_lines = {PORT_CHANGE_I, INT_SRC_I, EXT_IRQ_PIN_B_I,
                      EXT_IRQ_PIN_A_I, FREE_TIMER_OVF_I};
  // Pins need synchronising; timer and counters are on this clock.
  assign is_pin = (8'h01 << SRC_EXT_A) | (8'h01 << SRC_EXT_B) |
                  (8'h01 << SRC_PORT);

  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    vint_edge_sync u_sync (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .async_i(req_lines[g]),
      .sync_mode_i(is_pin[g]),
      .fall_o(fall[g])
    );
  end

  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & CE_I;
  assign rd_en = PSEL_I & ~PWRITE_I & CE_I;
  assign PREADY_O = 1'b1;
  assign addr_ok = (PADDR_I == ADDR_PENDING) || (PADDR_I == ADDR_MASK) ||
                   (PADDR_I == ADDR_CTRL) || (PADDR_I == ADDR_STATE) ||
                   (PADDR_I == ADDR_IRQ_STAT) || (PADDR_I == ADDR_IRQ_MASK);
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

  assign clr_bits = (wr_en && PADDR_I == ADDR_PENDING) ?
                    PWDATA_I[NUM_SRC-1:0] : '0;

  // A taken source's flag is cleared on acceptance; a new edge wins.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      pending_flag_register_r <= PENDING_RST;
    end else if (CE_I) begin
      pending_flag_register_r <= (pending_flag_register_r & ~clr_bits &
        ~(take ? (8'h01 << cur_idx_r) : 8'h00)) |
        (fall & source_mask_register_r);
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      source_mask_register_r <= MASK_RST;
    end else if (wr_en && PADDR_I == ADDR_MASK) begin
      source_mask_register_r <= PWDATA_I[NUM_SRC-1:0];
    end
  end

  // Disable wins when both instructions arrive together.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      gie_r <= 1'b0;
    end else if (CE_I) begin
      if (GLOBAL_DISABLE_INSTR_I) begin
        gie_r <= 1'b0;
      end else if (GLOBAL_ENABLE_INSTR_I) begin
        gie_r <= 1'b1;
      end else if (wr_en && PADDR_I == ADDR_CTRL) begin
        gie_r <= PWDATA_I[CTRL_GIE_BIT];
      end
    end
  end

  assign eligible = pending_flag_register_r & source_mask_register_r;
  assign sel_any = |eligible;
  assign sel_idx = low_idx(eligible);
  assign take = (state_r == ST_REQ) & TAKE_ACK_I & CE_I;
  assign done = (state_r == ST_SERVICE) & RETURN_I & CE_I;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
      cur_idx_r <= 3'h0;
      VECTOR_O <= 16'h0000;
      RESTORE_O <= 1'b0;
    end else if (CE_I) begin
      RESTORE_O <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (gie_r && sel_any) begin
            state_r <= ST_REQ;
            cur_idx_r <= sel_idx;
            VECTOR_O <= vec_of(sel_idx);
          end
        end
        ST_REQ: begin
          if (TAKE_ACK_I) begin
            state_r <= ST_SERVICE;
          end else if (!gie_r) begin
            state_r <= ST_IDLE;
          end
        end
        ST_SERVICE: begin
          if (RETURN_I) begin
            state_r <= ST_IDLE;
            RESTORE_O <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign TAKE_REQ_O = (state_r == ST_REQ);

  vint_context_store #(
    .DATA_W(DATA_W)
  ) u_ctx (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .save_i(take),
    .acc_i(ACCUMULATOR_I),
    .stat_i(CPU_STATUS_I),
    .acc_o(ACC_RESTORE_O),
    .stat_o(STATUS_RESTORE_O)
  );

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      istat_r <= 2'h0;
    end else if (CE_I) begin
      istat_r <= (istat_r & ~((wr_en && PADDR_I == ADDR_IRQ_STAT) ?
                 PWDATA_I[1:0] : 2'h0)) | {done, take};
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      imask_r <= 2'h0;
    end else if (wr_en && PADDR_I == ADDR_IRQ_MASK) begin
      imask_r <= PWDATA_I[1:0];
    end
  end

  assign IRQ_O = |(istat_r & imask_r);

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_en && !PENABLE_I) begin
      if (PADDR_I == ADDR_PENDING) begin
        PRDATA_O <= {24'h000000, pending_flag_register_r};
      end else if (PADDR_I == ADDR_MASK) begin
        PRDATA_O <= {24'h000000, source_mask_register_r};
      end else if (PADDR_I == ADDR_CTRL) begin
        PRDATA_O <= {31'h0, gie_r};
      end else if (PADDR_I == ADDR_STATE) begin
        PRDATA_O <= {27'h0, cur_idx_r, state_r == ST_SERVICE,
                     state_r == ST_REQ};
      end else if (PADDR_I == ADDR_IRQ_STAT) begin
        PRDATA_O <= {30'h0, istat_r};
      end else if (PADDR_I == ADDR_IRQ_MASK) begin
        PRDATA_O <= {30'h0, imask_r};
      end else begin
        PRDATA_O <= 32'h0000_0000;
      end
    end
  end

  property p_vector_range;
    @(posedge CLOCK_I) disable iff (RST_I)
      TAKE_REQ_O |-> (VECTOR_O == vec_of(cur_idx_r)) &&
        (VECTOR_O >= 16'h0003) && (VECTOR_O <= 16'h0018);
  endproperty
  a_vector_range: assert property (p_vector_range)
    else $error("Vector does not match the selected source.");

  property p_edge_set;
    @(posedge CLOCK_I) disable iff (RST_I)
      (CE_I && fall[SRC_EXT_A] && source_mask_register_r[SRC_EXT_A]) |=>
        pending_flag_register_r[SRC_EXT_A];
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("Unmasked falling edge did not set its flag.");

  property p_masked_nset;
    @(posedge CLOCK_I) disable iff (RST_I)
      (CE_I && !source_mask_register_r[SRC_CNT1] &&
       !pending_flag_register_r[SRC_CNT1]) |=>
        !pending_flag_register_r[SRC_CNT1];
  endproperty
  a_masked_nset: assert property (p_masked_nset)
    else $error("Masked source set its flag.");

  property p_no_nest;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_r == ST_SERVICE) |=> !TAKE_REQ_O;
  endproperty
  a_no_nest: assert property (p_no_nest)
    else $error("Interrupt vectored during service.");

  property p_save;
    @(posedge CLOCK_I) disable iff (RST_I)
      take |=> (ACC_RESTORE_O == $past(ACCUMULATOR_I)) &&
        (STATUS_RESTORE_O == $past(CPU_STATUS_I));
  endproperty
  a_save: assert property (p_save)
    else $error("Context not saved on take.");

  property p_restore;
    @(posedge CLOCK_I) disable iff (RST_I)
      done |=> RESTORE_O ##1 !RESTORE_O;
  endproperty
  a_restore: assert property (p_restore)
    else $error("Restore pulse missing after return.");

  property p_disable;
    @(posedge CLOCK_I) disable iff (RST_I)
      (CE_I && GLOBAL_DISABLE_INSTR_I) |=> !gie_r;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Disable instruction did not clear global enable.");

  property p_priority;
    @(posedge CLOCK_I) disable iff (RST_I)
      (CE_I && state_r == ST_IDLE && gie_r && eligible[0]) |=>
        (VECTOR_O == 16'h0003);
  endproperty
  a_priority: assert property (p_priority)
    else $error("Lowest vector not served first.");

  property p_pend_hold;
    @(posedge CLOCK_I) disable iff (RST_I)
      (CE_I && state_r == ST_SERVICE && pending_flag_register_r[SRC_CNT2] &&
       !clr_bits[SRC_CNT2]) |=> pending_flag_register_r[SRC_CNT2];
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("Request raised during service was lost.");

  property p_gie_gate;
    @(posedge CLOCK_I) disable iff (RST_I)
      (CE_I && state_r == ST_IDLE && !gie_r) |=> !TAKE_REQ_O;
  endproperty
  a_gie_gate: assert property (p_gie_gate)
    else $error("Interrupt vectored while globally disabled.");

  property p_req_hold;
    @(posedge CLOCK_I) disable iff (RST_I)
      (CE_I && TAKE_REQ_O && !TAKE_ACK_I && gie_r) |=>
        TAKE_REQ_O && $stable(VECTOR_O);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("Vector request dropped or changed before acceptance.");

  property p_ctx_hold;
    @(posedge CLOCK_I) disable iff (RST_I)
      !take |=> $stable(ACC_RESTORE_O) && $stable(STATUS_RESTORE_O);
  endproperty
  a_ctx_hold: assert property (p_ctx_hold)
    else $error("Saved context changed outside acceptance.");
endmodule
`default_nettype wire

// ### vint_cpu_model.sv
// Behavioural CPU core that accepts vectors and runs service routines.
`default_nettype none
module vint_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic take_req_i,
  input wire logic [15:0] vector_i,
  input wire logic [7:0] svc_len_i,
  output logic take_ack_o,
  output logic return_o,
  output logic [7:0] acc_o,
  output logic [7:0] stat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] vec_q[$];
  logic [7:0] acc_sv;
  logic [7:0] stat_sv;
  logic busy;
  initial begin
    take_ack_o = 1'b0;
    return_o = 1'b0;
    busy = 1'b0;
    acc_o = 8'h5A;
    stat_o = 8'hC3;
    forever begin
      @(posedge clk_i);
      if (!rst_i && take_req_i === 1'b1) begin
        busy = 1'b1;
        vec_q.push_back(vector_i);
        acc_sv = acc_o;
        stat_sv = stat_o;
        take_ack_o <= 1'b1;
        @(posedge clk_i);
        take_ack_o <= 1'b0;
        // The routine scribbles on the context so a late or missed save shows up.
        acc_o <= ~acc_o;
        stat_o <= stat_o + 8'h11;
        repeat (svc_len_i) @(posedge clk_i);
        return_o <= 1'b1;
        @(posedge clk_i);
        return_o <= 1'b0;
        busy = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_vint_unit.sv
// Self-checking bench for the vectored interrupt unit.
`default_nettype none
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected %s exp=%h got=%h", nm, e, g); \
  end \
end
module tb_vint_unit;
  import vint_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, pen, pwr, tack, tret, treq, rstr, irq;
  logic ready, slverr, err, gen, gdis, ce;
  logic [7:0] paddr, lines, svc, acc, st, acc_r, st_r;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] vec;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_restore = 0;
  logic [15:0] vt[8] = '{16'h0003, 16'h0006, 16'h0009, 16'h000C,
    16'h000F, 16'h0012, 16'h0015, 16'h0018};
  vint_unit vint_unit_inst (
    .CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(ready), .PSLVERR_O(slverr),
    .INT_SRC_I(lines[6:3]), .EXT_IRQ_PIN_A_I(lines[1]),
    .EXT_IRQ_PIN_B_I(lines[2]), .PORT_CHANGE_I(lines[7]),
    .GLOBAL_ENABLE_INSTR_I(gen), .GLOBAL_DISABLE_INSTR_I(gdis),
    .FREE_TIMER_OVF_I(lines[0]), .TAKE_ACK_I(tack), .RETURN_I(tret),
    .ACCUMULATOR_I(acc), .CPU_STATUS_I(st), .TAKE_REQ_O(treq),
    .VECTOR_O(vec), .RESTORE_O(rstr), .ACC_RESTORE_O(acc_r),
    .STATUS_RESTORE_O(st_r), .IRQ_O(irq));
  vint_cpu_model vint_cpu_model_inst (
    .clk_i(clk), .rst_i(rst), .take_req_i(treq), .vector_i(vec),
    .svc_len_i(svc), .take_ack_o(tack), .return_o(tret), .acc_o(acc),
    .stat_o(st));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Three cycles low lets the pin synchronisers see the falling edge.
  task automatic fire(input int i);
    lines[i] <= 1'b0;
    repeat (3) @(posedge clk);
    lines[i] <= 1'b1;
    @(posedge clk);
  endtask
  task automatic instr(input logic e);
    if (e) gen <= 1'b1;
    else gdis <= 1'b1;
    @(posedge clk);
    gen <= 1'b0;
    gdis <= 1'b0;
  endtask
  task automatic wait_take(input int n);
    for (int k = 0; k < 400 && vint_cpu_model_inst.vec_q.size() < n; k++)
      @(posedge clk);
    `CHK("takes", n, vint_cpu_model_inst.vec_q.size())
  endtask
  task automatic wait_idle();
    while (vint_cpu_model_inst.busy) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rstr === 1'b1) begin
      n_restore++;
      `CHK("acc", vint_cpu_model_inst.acc_sv, acc_r)
      `CHK("status", vint_cpu_model_inst.stat_sv, st_r)
    end
  end
  initial begin
    repeat (10000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lines = 8'hFF;
    gen = 1'b0;
    gdis = 1'b0;
    ce = 1'b1;
    svc = 8'h04;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, ADDR_PENDING, 32'h0);
    `CHK("pending", {24'h0, PENDING_RST}, rd)
    apb(1'b0, ADDR_MASK, 32'h0);
    `CHK("mask", {24'h0, MASK_RST}, rd)
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h4);
    fire(1);
    fire(2);
    apb(1'b0, ADDR_PENDING, 32'h0);
    `CHK("masked", 32'h4, rd)
    apb(1'b1, ADDR_MASK, 32'hFF);
    `CHK("idle", 1'b0, treq)
    instr(1'b1);
    wait_take(1);
    `CHK("vector", 16'h0009, vint_cpu_model_inst.vec_q[0])
    wait_idle();
    instr(1'b0);
    fire(0);
    repeat (6) @(posedge clk);
    `CHK("off", 1'b0, treq)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("gie off", 32'h0, rd)
    instr(1'b1);
    wait_take(2);
    wait_idle();
    for (int i = 0; i < 8; i++) begin
      fire(i);
      wait_take(3 + i);
      `CHK("vector", vt[i], vint_cpu_model_inst.vec_q[2 + i])
      wait_idle();
    end
    svc <= 8'h28;
    fire(6);
    wait_take(11);
    fire(4);
    fire(3);
    `CHK("nested", 1'b0, treq)
    apb(1'b0, ADDR_STATE, 32'h0);
    `CHK("state", 32'h1A, rd)
    wait_take(13);
    `CHK("first", 16'h000C, vint_cpu_model_inst.vec_q[11])
    `CHK("second", 16'h000F, vint_cpu_model_inst.vec_q[12])
    wait_idle();
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, ADDR_IRQ_STAT, 32'h3);
    `CHK("irq off", 1'b0, irq)
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    svc <= 8'h04;
    fire(0);
    wait_take(14);
    wait_idle();
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK("irq stat", 32'h3, rd)
    // With the clock enable low, neither a write nor an edge may land.
    ce <= 1'b0;
    apb(1'b1, ADDR_MASK, 32'h0);
    fire(0);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("frozen takes", 14, vint_cpu_model_inst.vec_q.size())
    apb(1'b0, ADDR_MASK, 32'h0);
    `CHK("frozen mask", 32'hFF, rd)
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("gie write", 32'h0, rd)
    fire(1);
    apb(1'b0, ADDR_PENDING, 32'h0);
    `CHK("pending set", 32'h2, rd)
    apb(1'b1, ADDR_PENDING, 32'h2);
    apb(1'b0, ADDR_PENDING, 32'h0);
    `CHK("pending clear", 32'h0, rd)
    `CHK("restores", 14, n_restore)
    finish_test();
  end
endmodule
`default_nettype wire
